// ### logic/analog_frontend_control.sv
// Analog front-end control block with AXI4-Lite register access
//
// Contract
// (RQ1) Control 0 bits 7:4 pick the mux channel for the converter comparator.
// (RQ2) Control 0 bit 3 ignores writes and reads as zero.
// (RQ3) Mux output enable routes the mux onto analog pin 0.
// (RQ4) Ramp reset stops the timer, discharges ramp; resets to one, register 02h.
// (RQ5) Zero select enables zeroing on both level-shifted inputs.
// (RQ6) Control 1 bits 7:4 select ramp current; register resets to 00h.
// (RQ7) Two-bit fields make 0, 1, 2 or 4 top pins of ports A, D digital.
// (RQ8) An N-bit conversion takes two to the N clock periods.
// (RQ9) Bandgap is channel 4, enabled while its power-down bit is clear.
// (RQ10) Level-shift networks enabled while their power-down bit is zero.
// (RQ11) Filter switch closed when sampling, opened while zero select is one.
// (RQ12) Temperature sensor is channel 7, enabled while its power-down is clear.
// (RQ13) After reset both comparators watch input one; B pin enable splits them.
// (RQ14) Comparator outputs read at bits 6 and 2; writes there ignored.
// (RQ15) Irq flag set while either output XOR its polarity is one.
// (RQ16) Irq reaches CPU only with flag, own, global, peripheral enables.
// (RQ17) Pin enable drives comparator output and reference onto pins.
// (RQ18) References and comparators enabled while comparator power-down clear.
// (RQ19) Reference select bits 7:3 pick coarse tap, bits 2:0 the fine tap.
// (RQ20) Coarse ladder has 32 taps in three ranges; fine ladder eight taps.
// (RQ21) References A and B appear on mux channels 8 and 9.
// (RQ22) Software holds ramp reset at least 200 us before each conversion.
// (RQ23) Channel codes 0 to 13 decode to sources; 14 and 15 reserved.
// (RQ24) Current code zero disables all sources; each step adds one source.
// (RQ25) Writes act at the completing edge; reads return written bits.
`timescale 1ns/1ps
`default_nettype none

module analog_frontend_control
	import afe_pkg::*;
#(
	parameter int unsigned DISCHARGE_CYC = DISCHARGE_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        comp_a_out,
	input  wire logic        comp_b_out,
	output var  afe_ctrl_t   afe_ctrl
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [7:0]  ctrl0;
		logic [7:0]  ctrl1;
		logic [7:0]  ref_a;
		logic [7:0]  ref_b;
		logic [7:0]  cmp_ctrl;
		logic [7:0]  sleep;
		logic [7:0]  irq_ctrl;
		logic [4:0]  resolution;
		logic        cmp_a;
		logic        cmp_b;
		logic [15:0] conv_count;
		logic        conv_done;
		logic [15:0] dis_count;
		logic        discharged;
		logic        aw_have;
		logic        w_have;
		logic [9:0]  w_idx;
		logic [7:0]  w_byte;
		logic        w_lane;
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		afe_ctrl_t   afe;
	} state_t;

	state_t st_q;
	state_t st_d;

	// ----------------------------------------------------------------
	// Decoders
	// ----------------------------------------------------------------
	// Thermometer of digital pins, highest pin first
	function automatic logic [3:0] port_digital(input logic [1:0] cfg);
		logic [3:0] r;
		r = 4'h0;
		unique case (cfg)
			2'h0: r = 4'h0;
			2'h1: r = 4'h8;
			2'h2: r = 4'hC;
			2'h3: r = 4'hF;
		endcase
		return r;
	endfunction

	// Coarse codes with low nibble at or above A sit in the 50 mV ranges
	function automatic logic [1:0] ref_range(input logic [4:0] crs);
		logic [1:0] r;
		r = RANGE_MIDDLE;
		if (crs[3:0] >= RANGE_SPLIT)
			r = crs[4] ? RANGE_LOWER : RANGE_UPPER;
		return r;
	endfunction

	// One enable per equal current step
	function automatic logic [14:0] steps(input logic [3:0] code);
		logic [14:0] r;
		r = 15'h0000;
		for (int i = 0; i < 15; i++)
			r[i] = (4'(i) < code);
		return r;
	endfunction

	function automatic logic mapped(input logic [9:0] idx);
		return idx inside {IDX_CTRL0, IDX_REF_A, IDX_REF_B, IDX_CMP,
			IDX_CTRL1, IDX_SLEEP, IDX_IRQ, IDX_CONV, IDX_STAT};
	endfunction

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		logic        cond;
		logic        do_wr;
		logic [9:0]  r_idx;
		logic [7:0]  wb;
		logic [7:0]  rb;
		logic [31:0] rw;
		logic [16:0] full;
		logic [15:0] last;
		logic [3:0]  ch;
		st_d  = st_q;
		cond  = 1'b0;
		do_wr = 1'b0;
		r_idx = s_axi_araddr[11:2];
		wb    = st_q.w_byte;
		rb    = 8'h00;
		rw    = 32'h0000_0000;
		full  = 17'h00001 << st_q.resolution;
		last  = 16'(full - 17'h00001);
		ch    = 4'h0;

		// Synchronous comparator samples
		st_d.cmp_a = comp_a_out;
		st_d.cmp_b = comp_b_out;

		// Write address and data are taken in either order
		if (s_axi_awvalid && st_q.awready)
		begin
			st_d.aw_have = 1'b1;
			st_d.w_idx   = s_axi_awaddr[11:2];
		end
		if (s_axi_wvalid && st_q.wready)
		begin
			st_d.w_have = 1'b1;
			st_d.w_byte = s_axi_wdata[7:0];
			st_d.w_lane = s_axi_wstrb[0];
		end

		// Commit once both halves are held [RQ25]
		if (st_q.aw_have && st_q.w_have && !st_q.bvalid)
		begin
			do_wr        = st_q.w_lane;
			st_d.aw_have = 1'b0;
			st_d.w_have  = 1'b0;
			st_d.bvalid  = 1'b1;
			st_d.bresp   = mapped(st_q.w_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_q.bvalid && s_axi_bready)
			st_d.bvalid = 1'b0;

		if (do_wr)
		begin
			unique case (st_q.w_idx)
				IDX_CTRL0: st_d.ctrl0 = wb & CTRL0_WMASK; // [RQ2]
				IDX_CTRL1: st_d.ctrl1 = wb; // [RQ6]
				IDX_REF_A: st_d.ref_a = wb;
				IDX_REF_B: st_d.ref_b = wb;
				IDX_CMP:   st_d.cmp_ctrl = wb & CMP_WMASK; // [RQ14]
				IDX_SLEEP: st_d.sleep = wb & SLEEP_WMASK;
				IDX_IRQ:
				begin
					st_d.irq_ctrl[2:0] = wb[2:0] & IRQ_WMASK[2:0];
					if (!wb[IRQ_FLAG])
						st_d.irq_ctrl[IRQ_FLAG] = 1'b0;
				end
				IDX_CONV:
				begin
					// Out-of-range resolutions are ignored
					if (wb[4:0] != 5'h00 && wb[4:0] <= RES_MAX)
						st_d.resolution = wb[4:0];
				end
				default: ;
			endcase
		end

		// Level-sensitive flag; a set beats a clear in the same cycle
		cond = (st_q.cmp_a ^ st_q.cmp_ctrl[CMP_A_POL])
			| (st_q.cmp_b ^ st_q.cmp_ctrl[CMP_B_POL]); // [RQ15]
		if (cond)
			st_d.irq_ctrl[IRQ_FLAG] = 1'b1; // [RQ15]

		// Conversion timer, one count per clock [RQ8]
		if (st_q.ctrl0[C0_RRST])
		begin
			st_d.conv_count = 16'h0000; // [RQ4]
			st_d.conv_done  = 1'b0;
		end
		else if (!st_q.conv_done)
		begin
			st_d.conv_count = st_q.conv_count + 16'h0001;
			if (st_q.conv_count == last)
				st_d.conv_done = 1'b1; // [RQ8]
		end

		// Discharge time watch; software owns the hold time [RQ22]
		if (!st_q.ctrl0[C0_RRST])
		begin
			st_d.dis_count  = 16'h0000;
			st_d.discharged = 1'b0;
		end
		else if (!st_q.discharged)
		begin
			st_d.dis_count = st_q.dis_count + 16'h0001;
			if (st_q.dis_count == 16'(DISCHARGE_CYC - 1))
				st_d.discharged = 1'b1;
		end

		// Read channel; answer carries the live register contents
		if (s_axi_arvalid && st_q.arready)
		begin
			unique case (r_idx)
				IDX_CTRL0: rb = st_q.ctrl0;
				IDX_CTRL1: rb = st_q.ctrl1;
				IDX_REF_A: rb = st_q.ref_a;
				IDX_REF_B: rb = st_q.ref_b;
				IDX_CMP:
				begin
					rb = st_q.cmp_ctrl;
					rb[CMP_A_OUT] = st_q.cmp_a; // [RQ14]
					rb[CMP_B_OUT] = st_q.cmp_b; // [RQ14]
				end
				IDX_SLEEP: rb = st_q.sleep;
				IDX_IRQ:   rb = st_q.irq_ctrl;
				IDX_CONV:  rb = {3'h0, st_q.resolution};
				default:   rb = 8'h00;
			endcase
			rw = {24'h00_0000, rb};
			if (r_idx == IDX_STAT)
				rw = {14'h0000, st_q.discharged, st_q.conv_done,
					st_q.conv_count};
			st_d.rvalid = 1'b1;
			st_d.rdata  = rw;
			st_d.rresp  = mapped(r_idx) ? RESP_OKAY : RESP_SLVERR;
		end
		else if (st_q.rvalid && s_axi_rready)
			st_d.rvalid = 1'b0;

		// Ready flags are flops: one item at a time per direction
		st_d.awready = !st_d.aw_have && !st_d.bvalid;
		st_d.wready  = !st_d.w_have && !st_d.bvalid;
		st_d.arready = !st_d.rvalid;

		// Analog controls follow the new register values [RQ25]
		ch = st_d.ctrl0[C0_CH_LSB +: 4]; // [RQ1]
		st_d.afe.channel_onehot = (ch <= CH_LAST)
			? (14'h0001 << ch) : 14'h0000; // [RQ23] [RQ21]
		st_d.afe.mux_to_pin0 = st_d.ctrl0[C0_MUXOE]; // [RQ3]
		st_d.afe.ramp_discharge = st_d.ctrl0[C0_RRST]; // [RQ4]
		st_d.afe.timer_run = !st_d.ctrl0[C0_RRST] && !st_d.conv_done;
		// Ramp reset also starves the current sources
		st_d.afe.current_steps = st_d.ctrl0[C0_RRST] ? 15'h0000
			: steps(st_d.ctrl1[C1_CUR_LSB +: 4]); // [RQ24] [RQ6]
		st_d.afe.zero_enable = st_d.ctrl0[C0_ZERO]; // [RQ5]
		st_d.afe.filter_switch_closed = !st_d.ctrl0[C0_ZERO]; // [RQ11]
		st_d.afe.port_a_digital =
			port_digital(st_d.ctrl1[C1_PA_LSB +: 2]); // [RQ7]
		st_d.afe.port_d_digital =
			port_digital(st_d.ctrl1[C1_PD_LSB +: 2]); // [RQ7]
		st_d.afe.bandgap_enable = !st_d.sleep[SLP_REF]; // [RQ9]
		st_d.afe.level_shift_enable = !st_d.sleep[SLP_LS]; // [RQ10]
		st_d.afe.temp_sensor_enable = !st_d.sleep[SLP_TEMP]; // [RQ12]
		st_d.afe.comparator_enable = !st_d.sleep[SLP_CMP]; // [RQ18]
		st_d.afe.window_mode = !st_d.cmp_ctrl[CMP_B_OE]; // [RQ13]
		st_d.afe.comp_a_pin_drive = st_d.cmp_ctrl[CMP_A_OE]; // [RQ17]
		st_d.afe.comp_b_pin_drive = st_d.cmp_ctrl[CMP_B_OE]; // [RQ17]
		st_d.afe.ref_a_coarse = st_d.ref_a[REF_CRS_LSB +: 5]; // [RQ19]
		st_d.afe.ref_a_fine   = st_d.ref_a[2:0]; // [RQ19]
		st_d.afe.ref_a_range  =
			ref_range(st_d.ref_a[REF_CRS_LSB +: 5]); // [RQ20]
		st_d.afe.ref_b_coarse = st_d.ref_b[REF_CRS_LSB +: 5]; // [RQ19]
		st_d.afe.ref_b_fine   = st_d.ref_b[2:0]; // [RQ19]
		st_d.afe.ref_b_range  =
			ref_range(st_d.ref_b[REF_CRS_LSB +: 5]); // [RQ20]
		st_d.afe.cpu_irq = st_d.irq_ctrl[IRQ_FLAG]
			&& st_d.irq_ctrl[IRQ_EN] && st_d.irq_ctrl[IRQ_GLOBAL]
			&& st_d.irq_ctrl[IRQ_PERI]; // [RQ16]
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q            <= '0;
			st_q.ctrl0      <= CTRL0_RST; // [RQ4]
			st_q.ctrl1      <= CTRL1_RST; // [RQ6]
			st_q.ref_a      <= REF_RST;
			st_q.ref_b      <= REF_RST;
			st_q.cmp_ctrl   <= CMP_RST;
			st_q.sleep      <= SLEEP_RST;
			st_q.irq_ctrl   <= IRQ_RST;
			st_q.resolution <= RES_RST;
			// Reset view of the controls matches the register defaults
			st_q.afe.channel_onehot       <= 14'h0001;
			st_q.afe.ramp_discharge       <= 1'b1;
			st_q.afe.filter_switch_closed <= 1'b1;
			st_q.afe.bandgap_enable       <= 1'b1;
			st_q.afe.level_shift_enable   <= 1'b1;
			st_q.afe.temp_sensor_enable   <= 1'b1;
			st_q.afe.comparator_enable    <= 1'b1;
			st_q.afe.window_mode          <= 1'b1;
		end
		else
			st_q <= st_d;
	end

	// ----------------------------------------------------------------
	// Outputs, all straight from the state flops
	// ----------------------------------------------------------------
	assign s_axi_awready = st_q.awready;
	assign s_axi_wready  = st_q.wready;
	assign s_axi_bvalid  = st_q.bvalid;
	assign s_axi_bresp   = st_q.bresp;
	assign s_axi_arready = st_q.arready;
	assign s_axi_rvalid  = st_q.rvalid;
	assign s_axi_rdata   = st_q.rdata;
	assign s_axi_rresp   = st_q.rresp;
	assign afe_ctrl      = st_q.afe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	bit_three_zero_a: assert property (!st_q.ctrl0[3]) // [RQ2]
		else $error("control 0 bit 3 not zero");

	ramp_hold_a: assert property (st_q.ctrl0[C0_RRST] |-> // [RQ4]
		afe_ctrl.ramp_discharge && !afe_ctrl.timer_run
		&& afe_ctrl.current_steps == 15'h0000)
		else $error("ramp reset does not hold the ramp");

	// Done first seen sixteen samples after the timer starts
	conv_length_a: assert property ( // [RQ8]
		$fell(st_q.ctrl0[C0_RRST]) && st_q.resolution == 5'h04
		|-> !st_q.conv_done [*8] ##8 !st_q.conv_done
		##1 st_q.conv_done)
		else $error("conversion length wrong");

	zero_switch_a: assert property (afe_ctrl.zero_enable // [RQ11]
		|-> !afe_ctrl.filter_switch_closed)
		else $error("filter switch closed while zeroing");

	flag_level_a: assert property ( // [RQ15]
		((st_q.cmp_a ^ st_q.cmp_ctrl[CMP_A_POL])
		|| (st_q.cmp_b ^ st_q.cmp_ctrl[CMP_B_POL]))
		|=> st_q.irq_ctrl[IRQ_FLAG])
		else $error("comparator flag not set");

	irq_gate_a: assert property (afe_ctrl.cpu_irq // [RQ16]
		|-> st_q.irq_ctrl[IRQ_EN] && st_q.irq_ctrl[IRQ_GLOBAL]
		&& st_q.irq_ctrl[IRQ_PERI] && st_q.irq_ctrl[IRQ_FLAG])
		else $error("irq without all enables");

	current_count_a: assert property (!st_q.ctrl0[C0_RRST] |-> // [RQ24]
		$countones(afe_ctrl.current_steps)
		== int'(st_q.ctrl1[C1_CUR_LSB +: 4]))
		else $error("current steps do not match code");

	reserved_chan_a: assert property ( // [RQ23]
		st_q.ctrl0[C0_CH_LSB +: 4] > CH_LAST
		|-> afe_ctrl.channel_onehot == 14'h0000)
		else $error("reserved channel selects a source");

	window_sel_a: assert property (afe_ctrl.window_mode // [RQ13]
		== !afe_ctrl.comp_b_pin_drive)
		else $error("window mode and pin enable disagree");

	write_resp_a: assert property ( // [RQ25]
		s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");

endmodule // analog_frontend_control

`default_nettype wire

// ### logic/afe_pkg.sv
// Constants, register map and carrier types for the analog front-end control
package afe_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_MHZ          = 25;
	localparam int unsigned DISCHARGE_US     = 200;
	localparam int unsigned DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [9:0] IDX_CTRL0 = 10'h01F;
	localparam logic [9:0] IDX_REF_A = 10'h09B;
	localparam logic [9:0] IDX_REF_B = 10'h09C;
	localparam logic [9:0] IDX_CMP   = 10'h09D;
	localparam logic [9:0] IDX_CTRL1 = 10'h09F;
	localparam logic [9:0] IDX_SLEEP = 10'h0A0;
	localparam logic [9:0] IDX_IRQ   = 10'h0A1;
	localparam logic [9:0] IDX_CONV  = 10'h0A2;
	localparam logic [9:0] IDX_STAT  = 10'h0A3;

	// ----------------------------------------------------------------
	// Reset values and write masks
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL0_RST   = 8'h02;
	localparam logic [7:0] CTRL1_RST   = 8'h00;
	localparam logic [7:0] REF_RST     = 8'h00;
	localparam logic [7:0] CMP_RST     = 8'h00;
	localparam logic [7:0] SLEEP_RST   = 8'h00;
	localparam logic [7:0] IRQ_RST     = 8'h00;
	localparam logic [4:0] RES_RST     = 5'h10;
	localparam logic [4:0] RES_MAX     = 5'h10;
	localparam logic [7:0] CTRL0_WMASK = 8'hF7;
	localparam logic [7:0] CMP_WMASK   = 8'h33;
	localparam logic [7:0] SLEEP_WMASK = 8'h36;
	localparam logic [7:0] IRQ_WMASK   = 8'h07;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int unsigned C0_CH_LSB   = 4;
	localparam int unsigned C0_MUXOE    = 2;
	localparam int unsigned C0_RRST     = 1;
	localparam int unsigned C0_ZERO     = 0;
	localparam int unsigned C1_CUR_LSB  = 4;
	localparam int unsigned C1_PD_LSB   = 2;
	localparam int unsigned C1_PA_LSB   = 0;
	localparam int unsigned REF_CRS_LSB = 3;
	localparam int unsigned CMP_B_OUT   = 6;
	localparam int unsigned CMP_B_OE    = 5;
	localparam int unsigned CMP_B_POL   = 4;
	localparam int unsigned CMP_A_OUT   = 2;
	localparam int unsigned CMP_A_OE    = 1;
	localparam int unsigned CMP_A_POL   = 0;
	localparam int unsigned SLP_REF     = 5;
	localparam int unsigned SLP_LS      = 4;
	localparam int unsigned SLP_CMP     = 2;
	localparam int unsigned SLP_TEMP    = 1;
	localparam int unsigned IRQ_FLAG    = 7;
	localparam int unsigned IRQ_EN      = 2;
	localparam int unsigned IRQ_PERI    = 1;
	localparam int unsigned IRQ_GLOBAL  = 0;

	// ----------------------------------------------------------------
	// Encodings
	// ----------------------------------------------------------------
	localparam logic [3:0] CH_LAST      = 4'hD;
	localparam logic [3:0] RANGE_SPLIT  = 4'hA;
	localparam logic [1:0] RANGE_MIDDLE = 2'h0;
	localparam logic [1:0] RANGE_UPPER  = 2'h1;
	localparam logic [1:0] RANGE_LOWER  = 2'h2;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// Controls driven toward the analog circuits
	typedef struct packed {
		logic [13:0] channel_onehot;
		logic        mux_to_pin0;
		logic        ramp_discharge;
		logic        timer_run;
		logic [14:0] current_steps;
		logic        zero_enable;
		logic        filter_switch_closed;
		logic [3:0]  port_a_digital;
		logic [3:0]  port_d_digital;
		logic        bandgap_enable;
		logic        level_shift_enable;
		logic        temp_sensor_enable;
		logic        comparator_enable;
		logic        window_mode;
		logic        comp_a_pin_drive;
		logic        comp_b_pin_drive;
		logic [4:0]  ref_a_coarse;
		logic [2:0]  ref_a_fine;
		logic [1:0]  ref_a_range;
		logic [4:0]  ref_b_coarse;
		logic [2:0]  ref_b_fine;
		logic [1:0]  ref_b_range;
		logic        cpu_irq;
	} afe_ctrl_t;

endpackage

// ### tb/comp_model.sv
// Comparator pair model standing in for the analog side
`timescale 1ns/1ps
`default_nettype none

module comp_model
(
	input  wire logic core_clk,
	input  wire logic enable,
	input  wire logic level_a,
	input  wire logic level_b,
	output var  logic comp_a_out,
	output var  logic comp_b_out
);
	// Powered-down comparators read low, never the old level
	always_ff @(posedge core_clk)
	begin
		comp_a_out <= enable & level_a;
		comp_b_out <= enable & level_b;
	end
endmodule // comp_model

`default_nettype wire

// ### tb/test_analog_frontend_control.sv
// Self-checking bench for the analog front-end control block
`timescale 1ns/1ps
`default_nettype none

module test_analog_frontend_control
	import afe_pkg::*;
;
	logic        core_clk, resetn, awvalid, wvalid, bready, arvalid, rready;
	logic [11:0] awaddr, araddr;
	logic [3:0]  wstrb;
	logic [31:0] wdata, s_axi_rdata;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        lvl_a, lvl_b, ca, cb;
	afe_ctrl_t   ctl;
	int          errors, n_tests;

	analog_frontend_control #(.DISCHARGE_CYC(8)) uut (
		.core_clk(core_clk), .resetn(resetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready),
		.comp_a_out(ca), .comp_b_out(cb), .afe_ctrl(ctl));

	comp_model cmp (.core_clk(core_clk), .enable(ctl.comparator_enable),
		.level_a(lvl_a), .level_b(lvl_b), .comp_a_out(ca), .comp_b_out(cb));

	// ----------------------------------------
	// Bus helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			errors++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [9:0] i, input logic [7:0] d,
		input logic [1:0] er);
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				awvalid <= 1'b0;
			if (s_axi_wready)
				wvalid <= 1'b0;
		end
		while (!s_axi_bvalid);
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [9:0] i, input logic [31:0] exp,
		input logic [1:0] er, input logic [31:0] m = 32'hFFFFFFFF);
		araddr <= {i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready)
				arvalid <= 1'b0;
		end
		while (!s_axi_rvalid);
		chk(s_axi_rdata & m, exp);
		chk(32'(s_axi_rresp), 32'(er));
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		chk(32'(ctl.channel_onehot), 32'h1);
		chk(32'({ctl.ramp_discharge, ctl.timer_run}), 32'h2);
		chk(32'(ctl.window_mode), 32'h1);
		rd(IDX_CTRL0, 32'h02, RESP_OKAY);
		rd(IDX_CTRL1, 32'h00, RESP_OKAY);
		wr(10'h3FF, 8'h55, RESP_SLVERR);
		rd(10'h3FF, 32'h0, RESP_SLVERR);
	endtask

	// Every channel code, reserved ones included
	task automatic t_ctrl0;
		wr(IDX_CTRL0, 8'hFF, RESP_OKAY);
		rd(IDX_CTRL0, 32'hF7, RESP_OKAY);
		chk(32'({ctl.mux_to_pin0, ctl.zero_enable,
			ctl.filter_switch_closed}), 32'h6);
		for (int c = 0; c < 16; c++)
		begin
			wr(IDX_CTRL0, {4'(c), 4'h2}, RESP_OKAY);
			chk(32'(ctl.channel_onehot), c < 14 ? 32'h1 << c : 32'h0);
		end
		chk(32'({ctl.mux_to_pin0, ctl.zero_enable,
			ctl.filter_switch_closed}), 32'h1);
	endtask

	task automatic t_ctrl1;
		logic [3:0] dig [4] = '{4'h0, 4'h8, 4'hC, 4'hF};
		for (int c = 0; c < 4; c++)
		begin
			wr(IDX_CTRL1, {4'h9, 2'(c), 2'(3 - c)}, RESP_OKAY);
			rd(IDX_CTRL1, {24'h0, 4'h9, 2'(c), 2'(3 - c)}, RESP_OKAY);
			chk(32'(ctl.port_d_digital), 32'(dig[c]));
			chk(32'(ctl.port_a_digital), 32'(dig[3 - c]));
			chk(32'(ctl.current_steps), 32'h0);
		end
	endtask

	task automatic t_refs;
		wr(IDX_REF_A, 8'hA5, RESP_OKAY);
		wr(IDX_REF_B, 8'h5A, RESP_OKAY);
		rd(IDX_REF_A, 32'hA5, RESP_OKAY);
		rd(IDX_REF_B, 32'h5A, RESP_OKAY);
		chk(32'({ctl.ref_a_coarse, ctl.ref_a_fine}), 32'hA5);
		chk(32'({ctl.ref_b_coarse, ctl.ref_b_fine}), 32'h5A);
		chk(32'({ctl.ref_a_range, ctl.ref_b_range}), 32'h1);
		// Lane 0 strobe low: the write is answered but ignored
		wstrb <= 4'h0;
		wr(IDX_REF_A, 8'h00, RESP_OKAY);
		wstrb <= 4'hF;
		rd(IDX_REF_A, 32'hA5, RESP_OKAY);
		wr(IDX_REF_A, 8'hD0, RESP_OKAY);
		chk(32'(ctl.ref_a_range), 32'(RANGE_LOWER));
	endtask

	task automatic t_sleep;
		wr(IDX_SLEEP, 8'hFF, RESP_OKAY);
		rd(IDX_SLEEP, 32'h36, RESP_OKAY);
		chk(32'({ctl.bandgap_enable, ctl.level_shift_enable,
			ctl.temp_sensor_enable, ctl.comparator_enable}), 32'h0);
		wr(IDX_SLEEP, 8'h00, RESP_OKAY);
		chk(32'({ctl.bandgap_enable, ctl.level_shift_enable,
			ctl.temp_sensor_enable, ctl.comparator_enable}), 32'hF);
	endtask

	// Flag is a level: a clear only sticks once the condition is gone
	task automatic t_comp;
		lvl_a <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(IDX_IRQ, 32'h80, RESP_OKAY);
		wr(IDX_CMP, 8'hFF, RESP_OKAY);
		rd(IDX_CMP, 32'h37, RESP_OKAY);
		chk(32'({ctl.window_mode, ctl.comp_a_pin_drive,
			ctl.comp_b_pin_drive}), 32'h3);
		wr(IDX_IRQ, 8'h07, RESP_OKAY);
		@(posedge core_clk);
		chk(32'(ctl.cpu_irq), 32'h1);
		wr(IDX_IRQ, 8'h06, RESP_OKAY);
		@(posedge core_clk);
		chk(32'(ctl.cpu_irq), 32'h0);
		wr(IDX_CMP, 8'h01, RESP_OKAY);
		wr(IDX_IRQ, 8'h07, RESP_OKAY);
		repeat (3) @(posedge core_clk);
		rd(IDX_IRQ, 32'h07, RESP_OKAY);
		chk(32'(ctl.cpu_irq), 32'h0);
		lvl_b <= 1'b1;
		repeat (4) @(posedge core_clk);
		rd(IDX_IRQ, 32'h87, RESP_OKAY);
		chk(32'(ctl.cpu_irq), 32'h1);
		wr(IDX_SLEEP, 8'h04, RESP_OKAY);
		repeat (4) @(posedge core_clk);
		rd(IDX_CMP, 32'h01, RESP_OKAY);
	endtask

	// Four-bit conversion: sixteen clocks after ramp reset clears
	task automatic t_conv;
		wr(IDX_CTRL1, 8'hF0, RESP_OKAY);
		wr(IDX_CONV, 8'h04, RESP_OKAY);
		wr(IDX_CTRL0, 8'h02, RESP_OKAY);
		repeat (10) @(posedge core_clk);
		// Ramp reset has been held far past the discharge time
		rd(IDX_STAT, 32'h20000, RESP_OKAY, 32'h3FFFF);
		chk(32'(ctl.current_steps), 32'h0);
		wr(IDX_CTRL0, 8'h00, RESP_OKAY);
		chk(32'({ctl.timer_run, ctl.ramp_discharge}), 32'h2);
		chk(32'(ctl.current_steps), 32'h7FFF);
		repeat (30) @(posedge core_clk);
		rd(IDX_STAT, 32'h10010, RESP_OKAY, 32'h3FFFF);
		chk(32'(ctl.timer_run), 32'h0);
	endtask

	// Reset in mid-run brings back the register defaults
	task automatic t_midreset;
		resetn <= 1'b0;
		repeat (2) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		chk(32'({ctl.ramp_discharge, ctl.timer_run}), 32'h2);
		rd(IDX_CTRL0, 32'h02, RESP_OKAY);
		rd(IDX_CTRL1, 32'h00, RESP_OKAY);
		rd(IDX_STAT, 32'h0, RESP_OKAY, 32'h1FFFF);
	endtask

	// ----------------------------------------
	// Clock, run control and verdict
	// ----------------------------------------
	task automatic final_report;
		if (errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		#(40 * 20000);
		errors++;
		final_report;
	end

	initial
	begin
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, lvl_a, lvl_b} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hF;
		errors = 0;
		n_tests = 0;
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		t_reset;
		t_ctrl0;
		t_ctrl1;
		t_refs;
		t_sleep;
		t_comp;
		t_conv;
		t_midreset;
		final_report;
	end
endmodule // test_analog_frontend_control

`default_nettype wire
